/* core/block_ram_pkg.sv */
package block_ram_pkg;
   // storage geometry
   localparam int TOTAL_BITS      = 4608;
   localparam int NARROW_DEPTH    = 512;
   localparam int NARROW_WIDTH    = 9;
   localparam int WIDE_DEPTH      = 256;
   localparam int WIDE_WIDTH      = 18;
   localparam int ADDR_WIDTH      = 9;
   localparam int HALF_ADDR_WIDTH = 8;
   // parity split of a word, for the user logic
   localparam int NARROW_DATA_BITS = 8;
   localparam int WIDE_DATA_BITS   = 16;
   // reset values
   localparam logic [WIDE_WIDTH-1:0] DOUT_RESET = 18'h00000;
endpackage : block_ram_pkg

/* core/bram_cell_array.sv */
`timescale 1ns/1ns
// two-port storage of 9-bit cells, one write and one registered read per port
module bram_cell_array #(
   parameter int DEPTH = 512,
   parameter int WIDTH = 9,
   parameter int AW    = 9
) (
   input  wire logic             ref_clk,
   input  wire logic             we_a,
   input  wire logic [AW-1:0]    waddr_a,
   input  wire logic [WIDTH-1:0] wdata_a,
   input  wire logic             we_b,
   input  wire logic [AW-1:0]    waddr_b,
   input  wire logic [WIDTH-1:0] wdata_b,
   input  wire logic [AW-1:0]    raddr_a,
   input  wire logic [AW-1:0]    raddr_b,
   output logic      [WIDTH-1:0] rdata_a,
   output logic      [WIDTH-1:0] rdata_b
);
   logic [WIDTH-1:0] cells [DEPTH];

   // port b written last: same-address collision is undefined anyway
   always_ff @(posedge ref_clk) begin
      if (we_a) begin
         cells[waddr_a] <= wdata_a;
      end
      if (we_b) begin
         cells[waddr_b] <= wdata_b;
      end
      rdata_a <= cells[raddr_a];
      rdata_b <= cells[raddr_b];
   end
endmodule : bram_cell_array

/* core/embedded_block_ram.sv */
`timescale 1ns/1ns
// The port clocks are modelled as qualified inputs sampled on ref_clk;
// an active port edge is a rising (or falling when inverted) transition.
module embedded_block_ram #(
   parameter logic [8:0] BLOCK_ID = 9'h000 // column position of this block
) (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        wide_mode,
   input  wire logic        read_only,
   input  wire logic        async_read,
   input  wire logic [8:0]  column_block_sel,
   input  wire logic        port_clk_a,
   input  wire logic        clk_invert_a,
   input  wire logic        clk_en_n_a,
   input  wire logic        write_en_a,
   input  wire logic        out_en_a,
   input  wire logic [8:0]  addr_a,
   input  wire logic [17:0] wdata_a,
   output logic      [17:0] rdata_a,
   input  wire logic        port_clk_b,
   input  wire logic        clk_invert_b,
   input  wire logic        clk_en_n_b,
   input  wire logic        write_en_b,
   input  wire logic        out_en_b,
   input  wire logic [8:0]  addr_b,
   input  wire logic [17:0] wdata_b,
   output logic      [17:0] rdata_b
);
   localparam int AW = block_ram_pkg::ADDR_WIDTH;
   localparam int NW = block_ram_pkg::NARROW_WIDTH;
   localparam int WW = block_ram_pkg::WIDE_WIDTH;

   localparam int HW = block_ram_pkg::HALF_ADDR_WIDTH;

   // pins gathered per port so one generate loop serves both
   wire  [1:0]    clk_pin = {port_clk_b, port_clk_a};
   wire  [1:0]    ce_pin  = {clk_en_n_b, clk_en_n_a};
   wire  [1:0]    we_pin  = {write_en_b, write_en_a};
   wire  [1:0]    oe_pin  = {out_en_b, out_en_a};
   wire  [1:0]    inv_pin = {clk_invert_b, clk_invert_a};
   wire  [AW-1:0] adr_pin [2];
   wire  [WW-1:0] dat_pin [2];

   // address and data buses indexed by port number
   assign adr_pin[0] = addr_a;
   assign adr_pin[1] = addr_b;
   assign dat_pin[0] = wdata_a;
   assign dat_pin[1] = wdata_b;

   // first and second stages of the mode and column synchronisers
   logic       wide_s1;
   logic       wide_s2;
   logic       ro_s1;
   logic       ro_s2;
   logic       ar_s1;
   logic       ar_s2;
   logic [8:0] sel_s1;
   logic [8:0] sel_s2;

   // mode pins pass two flip-flops
   always_ff @(posedge ref_clk) begin
      wide_s1 <= wide_mode;
      wide_s2 <= wide_s1;
      ro_s1   <= read_only;
      ro_s2   <= ro_s1;
      ar_s1   <= async_read;
      ar_s2   <= ar_s1;
      sel_s1  <= column_block_sel;
      sel_s2  <= sel_s1;
   end

   // column lines reach this block only when it is selected
   wire block_hit = (sel_s2 == BLOCK_ID);

   // bank 0 holds even narrow cells, bank 1 odd ones; a wide word spans both
   logic          bank_we [2][2]; // indexed [bank][port]
   logic [NW-1:0] bank_wd [2][2]; // indexed [bank][port]
   logic [NW-1:0] bank_rd [2][2]; // indexed [bank][port]
   logic [HW-1:0] row     [2];    // cell row of each port
   logic [WW-1:0] rd_reg  [2];    // captured read word of each port
   logic          oe_q    [2];    // output enable past the synchroniser

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         // synchroniser stages of this port's pins
         logic          clk_s1;
         logic          clk_s2;
         logic          clk_s3;
         logic          ce_s1;
         logic          ce_s2;
         logic          we_s1;
         logic          we_s2;
         logic          oe_s1;
         logic          oe_s2;
         logic          inv_s1;
         logic          inv_s2;
         logic [AW-1:0] adr_s1;
         logic [AW-1:0] adr_s2;
         logic [WW-1:0] dat_s1;
         logic [WW-1:0] dat_s2;
         logic          sync_q;

         // every port pin passes two flip-flops;
         // clk_s3 only delays the clock for the edge detector
         always_ff @(posedge ref_clk) begin
            clk_s1 <= clk_pin[p];
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            ce_s1  <= ce_pin[p];
            ce_s2  <= ce_s1;
            we_s1  <= we_pin[p];
            we_s2  <= we_s1;
            oe_s1  <= oe_pin[p];
            oe_s2  <= oe_s1;
            inv_s1 <= inv_pin[p];
            inv_s2 <= inv_s1;
            adr_s1 <= adr_pin[p];
            adr_s2 <= adr_s1;
            dat_s1 <= dat_pin[p];
            dat_s2 <= dat_s1;
         end

         // active edge: rising, or falling when inverted
         wire rise     = ~clk_s3 & clk_s2;
         wire fall     = clk_s3 & ~clk_s2;
         wire act_edge = inv_s2 ? fall : rise;

         // an edge counts only with clock enable low and the block selected
         wire enabled  = act_edge & ~ce_s2 & block_hit;
         wire do_write = enabled & we_s2 & ~ro_s2;
         wire do_read  = enabled & ~we_s2;
         wire odd      = adr_s2[0];

         // narrow: bit 0 picks the bank; wide: both banks at row [7:0]
         // both ports writing one address at one edge leave it undefined
         assign row[p]        = wide_s2 ? adr_s2[HW-1:0] : adr_s2[AW-1:1];
         assign bank_we[0][p] = do_write & (wide_s2 | ~odd);
         assign bank_we[1][p] = do_write & (wide_s2 | odd);

         // all 9 or 18 bits stored as given, parity included
         assign bank_wd[0][p] = dat_s2[NW-1:0];
         assign bank_wd[1][p] = wide_s2 ? dat_s2[WW-1:NW] : dat_s2[NW-1:0];

         // read word assembled; parity bits pass untouched
         wire [NW-1:0] narrow_rd = odd ? bank_rd[1][p] : bank_rd[0][p];
         wire [WW-1:0] word      = wide_s2 ? {bank_rd[1][p], bank_rd[0][p]}
                                           : {{(WW-NW){1'b0}}, narrow_rd};

         // sync mode captures after an enabled read edge; async follows address
         // read path: cell row registered, then rd_reg, then the output stage
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               rd_reg[p] <= block_ram_pkg::DOUT_RESET;
               sync_q    <= 1'b0;
               oe_q[p]   <= 1'b0;
            end else begin
               sync_q  <= do_read;
               oe_q[p] <= oe_s2;
               if (ar_s2 || sync_q) begin
                  rd_reg[p] <= word;
               end
            end
         end
      end
   endgenerate

   // one two-port cell array per bank; side a serves port 0, side b port 1
   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         bram_cell_array #(
            .DEPTH (block_ram_pkg::WIDE_DEPTH),
            .WIDTH (NW),
            .AW    (HW)
         ) u_bank (
            .ref_clk (ref_clk),
            .we_a    (bank_we[b][0]),
            .waddr_a (row[0]),
            .wdata_a (bank_wd[b][0]),
            .we_b    (bank_we[b][1]),
            .waddr_b (row[1]),
            .wdata_b (bank_wd[b][1]),
            .raddr_a (row[0]),
            .raddr_b (row[1]),
            .rdata_a (bank_rd[b][0]),
            .rdata_b (bank_rd[b][1])
         );
      end
   endgenerate

   // output enable low drives zero; both outputs from flip-flops
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_a <= block_ram_pkg::DOUT_RESET;
         rdata_b <= block_ram_pkg::DOUT_RESET;
      end else begin
         rdata_a <= oe_q[0] ? rd_reg[0] : block_ram_pkg::DOUT_RESET;
         rdata_b <= oe_q[1] ? rd_reg[1] : block_ram_pkg::DOUT_RESET;
      end
   end
endmodule : embedded_block_ram

/* tb/bram_checker.sv */
`timescale 1ns/1ns
// port-level rules of the block memory
module bram_checker (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        async_read,
   input wire logic        port_clk_a,
   input wire logic        port_clk_b,
   input wire logic        clk_en_n_a,
   input wire logic        clk_en_n_b,
   input wire logic        out_en_a,
   input wire logic        out_en_b,
   input wire logic [17:0] rdata_a,
   input wire logic [17:0] rdata_b
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // quiet port keeps its read word
   property p_still(logic pc, logic oe, logic [17:0] rd);
      ($stable(pc) && $stable(oe) && !async_read) [*8] |=> $stable(rd);
   endproperty
   property p_idle(logic cen, logic oe, logic [17:0] rd);
      (cen && $stable(oe) && !async_read) [*8] |=> $stable(rd);
   endproperty
   a_reset_clears_a: assert property ($fell(srst) |-> rdata_a == 18'h00000 ##1 rdata_a == 18'h00000) else $error("rdata_a not zero after reset");
   a_reset_clears_b: assert property ($fell(srst) |-> rdata_b == 18'h00000) else $error("rdata_b not zero after reset");
   a_oe_zero_a: assert property (!out_en_a [*5] |-> rdata_a == 18'h00000) else $error("rdata_a driven while disabled");
   a_oe_zero_b: assert property (!out_en_b [*5] |-> rdata_b == 18'h00000) else $error("rdata_b driven while disabled");
   a_sync_hold_a: assert property (p_still(port_clk_a, out_en_a, rdata_a)) else $error("rdata_a moved without edge");
   a_sync_hold_b: assert property (p_still(port_clk_b, out_en_b, rdata_b)) else $error("rdata_b moved without edge");
   a_ce_hold_a: assert property (p_idle(clk_en_n_a, out_en_a, rdata_a)) else $error("rdata_a moved while disabled");
   a_ce_hold_b: assert property (p_idle(clk_en_n_b, out_en_b, rdata_b)) else $error("rdata_b moved while disabled");
   // main scenarios
   c_edge_a: cover property (!clk_en_n_a && $rose(port_clk_a));
   c_oe_off_b: cover property (!out_en_b [*5]);
   c_reset: cover property ($fell(srst));
   c_async_b: cover property (async_read && $changed(rdata_b));
endmodule : bram_checker

bind embedded_block_ram bram_checker u_chk (.ref_clk, .srst, .async_read, .port_clk_a,
   .port_clk_b, .clk_en_n_a, .clk_en_n_b, .out_en_a, .out_en_b, .rdata_a, .rdata_b);

/* tb/fabric_port.sv */
`timescale 1ns/1ns
// user logic on one memory port
module fabric_port (
   input  wire logic ref_clk,
   output logic      port_clk = 1'b0,
   output logic      clk_invert = 1'b0,
   output logic      clk_en_n = 1'b1,
   output logic      write_en = 1'b0,
   output logic      out_en = 1'b1,
   output logic [8:0]  addr = 9'h000,
   output logic [17:0] wdata = 18'h00000
);
   // one port cycle, inputs held 4 ref_clk around each port edge
   task access(input logic en, input logic we, input logic [8:0] a, input logic [17:0] d);
      @(negedge ref_clk);
      clk_en_n = ~en;
      write_en = we;
      addr = a;
      wdata = d;
      repeat (4) @(negedge ref_clk);
      port_clk = ~clk_invert;
      repeat (4) @(negedge ref_clk);
      port_clk = clk_invert;
      repeat (4) @(negedge ref_clk);
      clk_en_n = 1'b1;
      addr = ~addr; // released lines lose last value
      wdata = ~wdata;
   endtask : access
   // output enable, changed at a falling edge like every other pin
   task enable(input logic oe);
      @(negedge ref_clk);
      out_en = oe;
   endtask : enable
   // idle level follows the chosen polarity
   task polarity(input logic inv);
      @(negedge ref_clk);
      clk_invert = inv;
      port_clk = inv;
      repeat (8) @(negedge ref_clk);
   endtask : polarity
endmodule : fabric_port

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
   logic ref_clk = 1'b0, srst = 1'b1, wide_mode = 1'b0, read_only = 1'b0, async_read = 1'b0;
   logic [8:0] column_block_sel = 9'h000, addr_a, addr_b;
   logic port_clk_a, clk_invert_a, clk_en_n_a, write_en_a, out_en_a;
   logic port_clk_b, clk_invert_b, clk_en_n_b, write_en_b, out_en_b;
   logic [17:0] wdata_a, wdata_b, rdata_a, rdata_b;
   int failures = 0, compares = 0;
   always #2 ref_clk = ~ref_clk;
   embedded_block_ram u_embedded_block_ram (.ref_clk, .srst, .wide_mode, .read_only,
      .async_read, .column_block_sel, .port_clk_a, .clk_invert_a, .clk_en_n_a, .write_en_a,
      .out_en_a, .addr_a, .wdata_a, .rdata_a, .port_clk_b, .clk_invert_b, .clk_en_n_b,
      .write_en_b, .out_en_b, .addr_b, .wdata_b, .rdata_b);
   fabric_port u_fa (.ref_clk, .port_clk(port_clk_a), .clk_invert(clk_invert_a),
      .clk_en_n(clk_en_n_a), .write_en(write_en_a), .out_en(out_en_a), .addr(addr_a),
      .wdata(wdata_a));
   fabric_port u_fb (.ref_clk, .port_clk(port_clk_b), .clk_invert(clk_invert_b),
      .clk_en_n(clk_en_n_b), .write_en(write_en_b), .out_en(out_en_b), .addr(addr_b),
      .wdata(wdata_b));
   task chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task results;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // both ports at once, narrow words with user parity
   task t_narrow;
      fork
         u_fa.access(1'b1, 1'b1, 9'h1ff, {9'h000, ^8'ha7, 8'ha7});
         u_fb.access(1'b1, 1'b1, 9'h000, 18'h001ff);
      join
      fork
         u_fa.access(1'b1, 1'b0, 9'h000, 18'h00000);
         u_fb.access(1'b1, 1'b0, 9'h1ff, 18'h00000);
      join
      chk("narrow a", 18'h001ff, rdata_a);
      chk("narrow b", {9'h000, ^8'ha7, 8'ha7}, rdata_b);
   endtask : t_narrow
   // wide word and its two narrow halves
   task t_wide;
      @(negedge ref_clk) wide_mode = 1'b1;
      u_fa.access(1'b1, 1'b1, 9'h07f, 18'h2b3c5);
      u_fb.access(1'b1, 1'b0, 9'h07f, 18'h00000);
      chk("wide", 18'h2b3c5, rdata_b);
      u_fb.access(1'b1, 1'b1, 9'h0c0, 18'h3fe01);
      u_fa.access(1'b1, 1'b0, 9'h0c0, 18'h00000);
      chk("wide a", 18'h3fe01, rdata_a);
      @(negedge ref_clk) wide_mode = 1'b0;
      u_fb.access(1'b1, 1'b0, 9'h0fe, 18'h00000);
      chk("low half", 18'h001c5, rdata_b);
      u_fb.access(1'b1, 1'b0, 9'h0ff, 18'h00000);
      chk("high half", 18'h00159, rdata_b);
   endtask : t_wide
   // read-only, other block selected, clock disabled
   task t_refuse;
      u_fa.access(1'b1, 1'b1, 9'h010, 18'h00055);
      for (int i = 0; i < 3; i++) begin
         @(negedge ref_clk);
         read_only = (i == 0);
         column_block_sel = {8'h00, i == 1};
         u_fa.access(i != 2, 1'b1, 9'h010, 18'h000aa);
         @(negedge ref_clk) column_block_sel = 9'h000;
         u_fb.access(1'b1, 1'b0, 9'h010, 18'h00000);
         chk("refused write", 18'h00055, rdata_b);
         read_only = 1'b0;
      end
   endtask : t_refuse
   // output enable gates a held word
   task t_oe;
      u_fb.enable(1'b0);
      u_fb.access(1'b1, 1'b0, 9'h1ff, 18'h00000);
      chk("disabled output", 18'h00000, rdata_b);
      u_fb.enable(1'b1);
      repeat (5) @(negedge ref_clk);
      chk("enabled output", {9'h000, ^8'ha7, 8'ha7}, rdata_b);
   endtask : t_oe
   // falling active edge, then a reset in mid-run
   task t_invert;
      u_fa.polarity(1'b1);
      u_fa.access(1'b1, 1'b1, 9'h123, 18'h00111);
      u_fa.access(1'b1, 1'b0, 9'h123, 18'h00000);
      chk("inverted clock", 18'h00111, rdata_a);
      u_fa.polarity(1'b0);
      srst = 1'b1;
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      chk("reset a", 18'h00000, rdata_a);
      chk("reset b", 18'h00000, rdata_b);
   endtask : t_invert
   // asynchronous read follows the address with the clock disabled
   task t_async;
      @(negedge ref_clk) async_read = 1'b1;
      u_fb.access(1'b0, 1'b0, 9'h123, 18'h00000);
      chk("async read", 18'h00111, rdata_b);
      @(negedge ref_clk) async_read = 1'b0;
   endtask : t_async
   initial begin
      repeat (16) @(negedge ref_clk);
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_narrow;
      t_wide;
      t_refuse;
      t_oe;
      t_invert;
      t_async;
      results;
   end
endmodule : tb
